// File: common/atr_pkg.sv
// atr_pkg: constants, register map and state types of the angular timer
// register block; shared by the core, the signal selector and the interface.
package atr_pkg;

    // register byte offsets on the AHB-Lite bus
    localparam logic [7:0] A_CLK_SEL  = 8'h00;
    localparam logic [7:0] A_SIG_SEL  = 8'h04;
    localparam logic [7:0] A_RES_HI   = 8'h08;
    localparam logic [7:0] A_RES_LO   = 8'h0C;
    localparam logic [7:0] A_MISS_HI  = 8'h10;
    localparam logic [7:0] A_MISS_LO  = 8'h14;
    localparam logic [7:0] A_PER_HI   = 8'h18;
    localparam logic [7:0] A_PER_LO   = 8'h1C;
    localparam logic [7:0] A_STATUS   = 8'h20;
    localparam logic [7:0] A_IRQ_STAT = 8'h24;
    localparam logic [7:0] A_IRQ_MASK = 8'h28;
    localparam int         ADDR_LSB   = 8;

    // field widths
    localparam int RES_W    = 10;
    localparam int RES_HI_W = 2;
    localparam int PER_W    = 15;
    localparam int MISS_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int SSEL_W   = 3;
    localparam int NSRC     = 8;
    localparam int IRQ_W    = 2;

    // status and interrupt bit positions
    localparam int IRQ_PER_BIT  = 0;
    localparam int IRQ_MISS_BIT = 1;
    localparam int OVF_BIT      = 7;

    // input cycles to wait after a resolution write
    localparam logic [1:0] INHIBIT_EDGES = 2'h2;

    // internal oscillator rate in MHz, for reference
    localparam int HF_OSC_MHZ = 16;

    // reset values
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [NSRC:0] s1;
        logic [NSRC:0] s2;
        logic          sel_prev;
        logic          osc_prev;
    } atr_sync_s;

    typedef struct packed {
        logic               clk_sel;
        logic [SSEL_W-1:0]  sig_sel;
        logic [RES_W-1:0]   res;
        logic [BYTE_W-1:0]  miss_hi_buf;
        logic [MISS_W-1:0]  miss;
        logic [PER_W-1:0]   per_cnt;
        logic               cnt_wrap;
        logic [PER_W-1:0]   period;
        logic               ovf;
        logic [1:0]         edge_cnt;
        logic               valid;
        logic               miss_fired;
        logic               miss_out;
        logic               per_out;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic               irq;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        hrdata;
        logic               hreadyout;
        logic               hresp;
    } atr_state_s;

endpackage

// File: common/atr_sig_if.sv
// atr_sig_if: carries source select and conditioned events between the
// register core and the signal selector; both sit on hclk.
`timescale 1ns/1ns
interface atr_sig_if;
    import atr_pkg::*;
    logic [SSEL_W-1:0] sel;
    logic              clk_sel;
    logic              sig_edge;
    logic              tick;
    modport sel_side (input sel, input clk_sel, output sig_edge, output tick);
    modport core_side (output sel, output clk_sel, input sig_edge, input tick);
endinterface

// File: src/atr_sig_sel.sv
// atr_sig_sel: synchronises the eight pulse sources and the internal
// oscillator, picks one source and gives its rising edges and timer ticks.
// assumes the pulse sources and oscillator are asynchronous to hclk; sel and clk_sel come from hclk.
`timescale 1ns/1ns
module atr_sig_sel
    import atr_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [NSRC-1:0] src,
    input  wire logic       hf_osc,
    atr_sig_if.sel_side     sig
);
    atr_sync_s q_reg;
    atr_sync_s q_next;

    ////////////////////////////////////////////////////////////////////////
    // two stages per input; only stage two feeds the mux and edge logic
    always_comb
    begin
        q_next          = q_reg;
        q_next.s1       = {hf_osc, src};
        q_next.s2       = q_reg.s1;
        q_next.sel_prev = q_reg.s2[sig.sel];
        q_next.osc_prev = q_reg.s2[NSRC];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            q_reg <= '0;
        else
            q_reg <= q_next;
    end

    // a source change may fake one edge; software switches sources stopped
    assign sig.sig_edge = q_reg.s2[sig.sel] & ~q_reg.sel_prev;
    // oscillator edges become ticks; else every system clock counts
    assign sig.tick = sig.clk_sel ? (q_reg.s2[NSRC] & ~q_reg.osc_prev) : 1'b1;
endmodule

// File: src/atr_top.sv
// atr_top: angular timer configuration and measurement registers with an
// AHB-Lite slave, period measurement, missing-pulse detection, interrupts.
// assumes one hclk domain; pulse sources and oscillator are asynchronous.
//
// How it works
// - clock-select bit 1 counts internal 16 MHz oscillator ticks, 0 system clock
// - 3-bit select picks logic cells, zero-cross, comparators or remappable pin
// - resolution is 10 bits: 2 in the high register, 8 in the low
// - resolution write clears valid and blocks outputs for two input cycles
// - signed 16-bit delay plus latched period gives the missing-pulse point
// - delay high byte is buffered until the low byte is written
// - measured period is 15 read-only bits, upper seven in period high
// - unused upper bits of select and resolution registers read zero
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module atr_top
    import atr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        remappable_input_pin,
    input  wire logic        comparator_one_synced,
    input  wire logic        comparator_two_synced,
    input  wire logic        zero_cross_output,
    input  wire logic        logic_cell_one_output,
    input  wire logic        logic_cell_two_output,
    input  wire logic        logic_cell_three_output,
    input  wire logic        logic_cell_four_output,
    input  wire logic        internal_hf_oscillator,
    output logic             irq,
    output logic             period_pulse,
    output logic             missing_pulse,
    output logic             measurement_valid,
    output logic [RES_W-1:0] phase_resolution
);
    atr_state_s q_reg;
    atr_state_s q_next;
    atr_sig_if  sig ();

    logic [NSRC-1:0] src_vec;
    logic            addr_ok;
    logic            wr_now;
    logic [7:0]      wd;
    logic [MISS_W-1:0] miss_point;
    logic            outs_on;
    logic [IRQ_W-1:0] irq_ev;

    ////////////////////////////////////////////////////////////////////////
    // source order follows the select code, index equals code
    assign src_vec = {logic_cell_four_output,
                      logic_cell_three_output,
                      logic_cell_two_output,
                      logic_cell_one_output,
                      zero_cross_output,
                      comparator_two_synced,
                      comparator_one_synced,
                      remappable_input_pin};

    assign sig.sel     = q_reg.sig_sel;
    assign sig.clk_sel = q_reg.clk_sel;

    atr_sig_sel u_sel
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .src     (src_vec),
        .hf_osc  (internal_hf_oscillator),
        .sig     (sig.sel_side)
    );

    ////////////////////////////////////////////////////////////////////////
    // read value of one register word; unmapped words read zero
    function automatic logic [31:0] rd_word(input atr_state_s s,
                                            input logic [7:0] a);
        logic [31:0] v;
        v = WORD_ZERO;
        unique case (a)
            A_CLK_SEL:  v[0] = s.clk_sel;
            A_SIG_SEL:  v[SSEL_W-1:0] = s.sig_sel;
            A_RES_HI:   v[RES_HI_W-1:0] = s.res[RES_W-1:BYTE_W];
            A_RES_LO:   v[BYTE_W-1:0] = s.res[BYTE_W-1:0];
            A_MISS_HI:  v[BYTE_W-1:0] = s.miss_hi_buf;
            A_MISS_LO:  v[BYTE_W-1:0] = s.miss[BYTE_W-1:0];
            A_PER_HI:
            begin
                v[OVF_BIT] = s.ovf;
                v[PER_W-BYTE_W-1:0] = s.period[PER_W-1:BYTE_W];
            end
            A_PER_LO:   v[BYTE_W-1:0] = s.period[BYTE_W-1:0];
            A_STATUS:   v[0] = s.valid;
            A_IRQ_STAT: v[IRQ_W-1:0] = s.irq_stat;
            A_IRQ_MASK: v[IRQ_W-1:0] = s.irq_mask;
            default:    v = WORD_ZERO;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode: a transfer is taken on a valid address phase
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_now  = q_reg.wr_pend;
    assign wd      = hwdata[BYTE_W-1:0];

    // missing-pulse point: latched period plus the signed delay
    assign miss_point = {1'b0, q_reg.period} + q_reg.miss;

    // outputs stay blocked until enough input cycles followed a resolution write
    assign outs_on = (q_reg.edge_cnt >= INHIBIT_EDGES);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: measurement first, then register writes, then bus
    always_comb
    begin
        q_next = q_reg;
        q_next.per_out  = 1'b0;
        q_next.miss_out = 1'b0;
        q_next.wr_pend  = 1'b0;
        // events of this cycle, so a write-one-clear cannot swallow them
        irq_ev          = '0;

        // period counter runs on the selected timer clock tick
        if (sig.tick)
        begin
            q_next.per_cnt = q_reg.per_cnt + 1'b1;
            if (&q_reg.per_cnt)
                q_next.cnt_wrap = 1'b1;
        end

        // active edge latches the measured period and restarts the count
        if (sig.sig_edge)
        begin
            q_next.period     = q_reg.per_cnt;
            q_next.ovf        = q_reg.cnt_wrap;
            q_next.per_cnt    = '0;
            q_next.cnt_wrap   = 1'b0;
            q_next.miss_fired = 1'b0;
            if (q_reg.edge_cnt < INHIBIT_EDGES)
                q_next.edge_cnt = q_reg.edge_cnt + 1'b1;
            if (outs_on)
            begin
                q_next.per_out = 1'b1;
                q_next.irq_stat[IRQ_PER_BIT] = 1'b1;
                irq_ev[IRQ_PER_BIT] = 1'b1;
            end
        end
        else if (!q_reg.miss_fired && outs_on &&
                 ({1'b0, q_reg.per_cnt} == miss_point))
        begin
            // one missing-pulse event per input period
            q_next.miss_fired = 1'b1;
            q_next.miss_out   = 1'b1;
            q_next.irq_stat[IRQ_MISS_BIT] = 1'b1;
            irq_ev[IRQ_MISS_BIT] = 1'b1;
        end

        // data phase of a write; write-one-clear loses to a new event
        if (wr_now)
        begin
            unique case (q_reg.wr_addr)
                A_CLK_SEL:  q_next.clk_sel = wd[0];
                A_SIG_SEL:  q_next.sig_sel = wd[SSEL_W-1:0];
                A_RES_HI:
                begin
                    q_next.res[RES_W-1:BYTE_W] = wd[RES_HI_W-1:0];
                    q_next.edge_cnt = '0;
                    q_next.per_out  = 1'b0;
                    q_next.miss_out = 1'b0;
                    q_next.valid    = 1'b0;
                end
                A_RES_LO:
                begin
                    q_next.res[BYTE_W-1:0] = wd;
                    q_next.edge_cnt = '0;
                    q_next.per_out  = 1'b0;
                    q_next.miss_out = 1'b0;
                    q_next.valid    = 1'b0;
                end
                A_MISS_HI:  q_next.miss_hi_buf = wd;
                A_MISS_LO:  q_next.miss = {q_reg.miss_hi_buf, wd};
                A_IRQ_STAT:
                    q_next.irq_stat = (q_reg.irq_stat & ~hwdata[IRQ_W-1:0]) | irq_ev;
                A_IRQ_MASK: q_next.irq_mask = hwdata[IRQ_W-1:0];
                // period and status registers are read-only, other words unmapped
                default:    q_next.irq_mask = q_reg.irq_mask;
            endcase
        end

        // valid follows the input cycle count unless just cleared
        if (!(wr_now && (q_reg.wr_addr == A_RES_HI ||
                         q_reg.wr_addr == A_RES_LO)))
            q_next.valid = (q_next.edge_cnt >= INHIBIT_EDGES);

        // read data taken from the updated state, so a read right after
        // a write sees the new value
        if (addr_ok && !hwrite)
            q_next.hrdata = rd_word(q_next, haddr[ADDR_LSB-1:0]);
        if (addr_ok && hwrite)
        begin
            q_next.wr_pend = 1'b1;
            q_next.wr_addr = haddr[ADDR_LSB-1:0];
        end

        // zero-wait slave, always OKAY
        q_next.hreadyout = 1'b1;
        q_next.hresp     = 1'b0;
        q_next.irq = |(q_next.irq_stat & q_next.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // the whole state in one register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q_reg           <= '0;
            q_reg.hreadyout <= 1'b1;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from state flops
    assign hrdata            = q_reg.hrdata;
    assign hreadyout         = q_reg.hreadyout;
    assign hresp             = q_reg.hresp;
    assign irq               = q_reg.irq;
    assign period_pulse      = q_reg.per_out;
    assign missing_pulse     = q_reg.miss_out;
    assign measurement_valid = q_reg.valid;
    assign phase_resolution  = q_reg.res;

endmodule

// File: verification/atr_src_model.sv
// atr_src_model: pulse sources and internal oscillator beside the timer.
// assumes the bench picks the source, the period in hclk cycles and run.
`timescale 1ns/1ns
module atr_src_model
(
    input  wire logic       hclk,
    input  wire logic [2:0] sel,
    input  wire logic [9:0] per,
    input  wire logic       run,
    output logic      [7:0] src,
    output logic            osc
);
    int cnt = 0;
    ////////////////////////////////////////
    // free running oscillator near 16 MHz, never phase locked to hclk
    initial
    begin
        osc = 1'b0;
        src = 8'h00;
        forever #31 osc = ~osc;
    end
    // selected line pulses four cycles wide; others toggle to expose bad routing
    always @(posedge hclk)
    begin
        cnt <= (cnt + 1 >= int'(per)) ? 0 : cnt + 1;
        for (int i = 0; i < 8; i++)
            src[i] <= run && ((i == int'(sel)) ? cnt < 4 : cnt[1]);
    end
endmodule

// File: verification/atr_chk.sv
// atr_chk: bus and measurement relations seen at the atr_top ports.
// assumes one hclk domain and a single AHB-Lite master.
`timescale 1ns/1ns
module atr_chk
    import atr_pkg::*;
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             period_pulse,
    input wire logic             missing_pulse,
    input wire logic             measurement_valid,
    input wire logic [RES_W-1:0] phase_resolution
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       wr_q;
    logic       rd_q;
    logic [7:0] a_q;
    ////////////////////////////////////////
    // mark the data phase behind each taken address phase
    always_ff @(posedge hclk)
    begin
        wr_q <= hsel && hready && htrans[1] && hwrite;
        rd_q <= hsel && hready && htrans[1] && !hwrite;
        a_q  <= haddr[7:0];
    end
    // resolution bytes reach the port one cycle after their data phase
    chk_res_low_load:
    assert property (wr_q && a_q == A_RES_LO |=> phase_resolution[7:0] == $past(hwdata[7:0]))
        else $error("resolution low byte not loaded");
    chk_res_high_load:
    assert property (wr_q && a_q == A_RES_HI |=> phase_resolution[9:8] == $past(hwdata[1:0]))
        else $error("resolution high bits not loaded");
    chk_res_kills_valid:
    assert property (wr_q && (a_q == A_RES_HI || a_q == A_RES_LO) |=>
        (!measurement_valid && !period_pulse) [*3]) else $error("valid survived write");
    // outputs stay quiet while the measurement is not valid
    chk_pulse_gated:
    assert property ((!measurement_valid) [*2] |-> !period_pulse)
        else $error("period pulse while invalid");
    chk_miss_gated:
    assert property ((!measurement_valid) [*2] |-> !missing_pulse)
        else $error("missing pulse while invalid");
    chk_miss_once:
    assert property (missing_pulse |=> !missing_pulse [*4])
        else $error("missing pulse repeated");
    // unimplemented upper bits read as zero
    chk_clk_sel_zero:
    assert property (rd_q && a_q == A_CLK_SEL |-> hrdata[31:1] == 31'h0)
        else $error("clock select upper bits set");
    chk_sig_sel_zero:
    assert property (rd_q && a_q == A_SIG_SEL |-> hrdata[31:3] == 29'h0)
        else $error("signal select upper bits set");
    chk_res_hi_zero:
    assert property (rd_q && a_q == A_RES_HI |-> hrdata[31:2] == 30'h0)
        else $error("resolution high upper bits set");
    cover property (period_pulse);
    cover property (missing_pulse);
    cover property ($rose(measurement_valid));
endmodule

bind atr_top atr_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .period_pulse(period_pulse), .missing_pulse(missing_pulse),
    .measurement_valid(measurement_valid), .phase_resolution(phase_resolution));

// File: verification/testbench.sv
// testbench: drives atr_top over AHB-Lite, checks registers and timing.
// assumes atr_src_model for the sources and atr_chk bound to the top.
`timescale 1ns/1ns
module testbench
    import atr_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rnd = 32'h2E766739;
    logic [31:0] hrdata, rdat;
    logic        hreadyout, hresp, irq, period_pulse, missing_pulse, measurement_valid, osc;
    logic [9:0]  phase_resolution;
    logic [7:0]  src;
    logic [2:0]  m_sel = 3'h0;
    logic [9:0]  m_per = 10'h20;
    logic        m_run = 1'b0;
    logic [15:0] per_seen;
    logic [31:0] wr [8];
    logic [31:0] msk [8] = '{32'h1, 32'h7, 32'h3, 32'hFF, 32'hFF, 32'hFF, 32'h0, 32'h0};
    int          num_errors = 0;
    int          num_checks = 0;
    ////////////////////////////////////////
    atr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .remappable_input_pin(src[0]), .comparator_one_synced(src[1]),
        .comparator_two_synced(src[2]), .zero_cross_output(src[3]),
        .logic_cell_one_output(src[4]), .logic_cell_two_output(src[5]),
        .logic_cell_three_output(src[6]), .logic_cell_four_output(src[7]),
        .internal_hf_oscillator(osc), .irq(irq), .period_pulse(period_pulse),
        .missing_pulse(missing_pulse), .measurement_valid(measurement_valid),
        .phase_resolution(phase_resolution));
    atr_src_model SRC (.hclk(hclk), .sel(m_sel), .per(m_per), .run(m_run), .src(src),
        .osc(osc));
    // 8 ns system clock
    initial
    begin
        forever #4 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic bail();
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        finish_test();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    // bounded wait for ready; never trusts a fixed latency
    task automatic wait_rdy();
        for (int n = 0; n < 50; n++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        bail();
    endtask
    // one single word transfer; read data lands in rdat
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdat = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_pp(input int k);
        int n;
        n = 0;
        for (int c = 0; c < 5000 && n < k; c++)
        begin
            @(posedge hclk);
            if (period_pulse === 1'b1)
                n++;
        end
        if (n < k)
            bail();
    endtask
    // cycles from a period pulse to the next missing pulse, two of slack
    task automatic miss_gap(input logic stop, input int want);
        int n;
        wait_pp(1);
        m_run <= !stop;
        n = 0;
        while (missing_pulse !== 1'b1 && n < 3000)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000)
            bail();
        check(32'(n > want - 3 && n < want + 3), 32'h1);
    endtask
    // new source and period; a resolution write restarts validity
    task automatic measure(input logic [2:0] s, input logic [9:0] p);
        // stop the source and let edges in flight drain before touching setup
        m_run <= 1'b0;
        repeat (4) @(posedge hclk);
        m_sel <= s;
        m_per <= p;
        bus(1'b1, A_SIG_SEL, {29'h0, s});
        bus(1'b1, A_RES_LO, rnd);
        m_run <= 1'b1;
        @(posedge hclk);
        check(measurement_valid, 1'b0);
        wait_pp(2);
        check(measurement_valid, 1'b1);
        bus(1'b0, A_PER_LO, 32'h0);
        per_seen[7:0] = rdat[7:0];
        bus(1'b0, A_PER_HI, 32'h0);
        per_seen[15:8] = rdat[7:0];
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 'h3C; a += 4)
        begin
            bus(1'b0, 8'(a), 32'h0);
            check(rdat, 32'h0);
        end
        $display("reset values done");
        // random writes; unused bits and the period words stay zero
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            wr[i] = rnd;
            bus(1'b1, 8'(4 * i), rnd);
            bus(1'b0, 8'(4 * i), 32'h0);
            check(rdat, rnd & msk[i]);
        end
        check({22'h0, phase_resolution}, {22'h0, wr[2][1:0], wr[3][7:0]});
        bus(1'b1, A_CLK_SEL, 32'h0);
        $display("register map done");
        for (int s = 0; s < 8; s++)
        begin
            rnd = lfsr(rnd);
            measure(3'(s), 10'(20 + rnd[5:0]));
            check({16'h0, per_seen}, {22'h0, m_per - 10'h1});
        end
        $display("source select done");
        // high byte waits in its buffer until the low byte lands
        bus(1'b1, A_MISS_HI, 32'h0);
        bus(1'b1, A_MISS_LO, 32'hA);
        bus(1'b1, A_MISS_HI, 32'hFF);
        bus(1'b0, A_MISS_HI, 32'h0);
        check(rdat, 32'hFF);
        bus(1'b1, A_IRQ_MASK, 32'h2);
        miss_gap(1'b1, int'(m_per) + 9);
        check(irq, 1'b1);
        bus(1'b1, A_IRQ_STAT, 32'h2);
        bus(1'b0, A_IRQ_STAT, 32'h0);
        check(rdat & 32'h2, 32'h0);
        check(irq, 1'b0);
        // silence longer than the 15-bit counter range forces a wrap
        repeat (33000) @(posedge hclk);
        m_run <= 1'b1;
        wait_pp(1);
        bus(1'b0, A_PER_HI, 32'h0);
        check(rdat & 32'h80, 32'h80);
        wait_pp(1);
        bus(1'b0, A_PER_HI, 32'h0);
        check(rdat & 32'h80, 32'h0);
        bus(1'b1, A_MISS_HI, 32'hFF);
        bus(1'b1, A_MISS_LO, 32'hF6);
        miss_gap(1'b0, int'(m_per) - 11);
        $display("missing pulse done");
        // oscillator ticks: 248 hclk cycles hold about 32 of them
        bus(1'b1, A_CLK_SEL, 32'h1);
        measure(3'h0, 10'hF8);
        check(32'(per_seen > 16'h1D && per_seen < 16'h22), 32'h1);
        $display("clock select done");
        finish_test();
    end
endmodule
